// [design/cell_balance_map.svh]
// Purpose: Register offsets, field codes and timing counts for the cell balance block
// Assumes: 32-bit APB, byte addresses, pclk at 40 MHz
// Notes:   Definitions only
`ifndef CELL_BALANCE_MAP_SVH
`define CELL_BALANCE_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BAL_CTRL_ADDR 12'h080
`define BAL_STATUS_ADDR 12'h084
`define BAL_CTRL_RESET 14'h0000
`define BAL_STATE_LSB 14
`define BAL_UNIT_LSB 12

// ----------------------------------------
// Field codes
// ----------------------------------------
`define MODE_DISABLED 3'h0
`define MODE_DISCHARGE 3'h1
`define MODE_MAN_SEC 3'h2
`define MODE_MAN_MIN 3'h3
`define MODE_AUTO_IND_SEC 3'h4
`define MODE_AUTO_GRP_SEC 3'h6
`define STATE_OFF 2'h0
`define STATE_ACTIVE 2'h1
`define STATE_DONE 2'h2
`define STATE_HALT 2'h3
`define HOLD_NONE 2'h0
`define HOLD_OP 2'h1
`define HOLD_EXT 2'h2
`define HOLD_KEEP 2'h3
`define UNIT_NONE 2'h0
`define UNIT_SEC 2'h1
`define UNIT_MIN 2'h2
`define UNIT_HOUR 2'h3
`define MEAS_CHECK 2'h3
`define EXPIRY_INFINITE 10'h3FF
`define SETTLE_SCANS 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_PERIOD_NS 25
`define SECOND_NS 1000000000
`define SEC_CYCLES (`SECOND_NS / `PCLK_PERIOD_NS)
`define HOLD_MIN_MINUTES 5
`define HOLD_MIN_S (`HOLD_MIN_MINUTES * 60)

`endif

// [design/cell_balance_pkg.sv]
// Purpose: Types shared by the cell balance block
// Assumes: Nothing beyond the map header
// Notes:   Control word layout matches register bits 13:0
package cell_balance_pkg;

    typedef struct packed {
        logic [2:0] balance_mode_sel;
        logic filter_init_req;
        logic [1:0] shutdown_hold_sel;
        logic [3:0] balance_duty;
        logic done_alert_en;
        logic thermal_exit_en;
        logic [1:0] embedded_meas_en;
    } ctrl_t;

    typedef struct packed {
        logic sec;
        logic min;
        logic hour;
    } tick_t;

    typedef enum logic [1:0] {RUN_IDLE, RUN_ACTIVE, RUN_HOLD} run_state_t;

endpackage : cell_balance_pkg

// [design/balance_timebase.sv]
// Purpose: Second, minute and hour ticks for the balance timer
// Assumes: restart realigns all counters
// Notes:   Ticks are one-cycle pulses
`timescale 1ns/1ps
`include "cell_balance_map.svh"
module balance_timebase
    import cell_balance_pkg::*;
#(
    parameter int SEC_CYCLES = `SEC_CYCLES
)
(
    input wire logic pclk,     // Clock
    input wire logic presetn,  // Async reset, active low
    input wire logic restart,  // Realign to zero
    output tick_t tick         // Unit pulses
);
    logic [25:0] cyc;
    logic [5:0] secs;
    logic [5:0] mins;
    logic sec_end;
    logic min_end;

    assign sec_end = (cyc == 26'(SEC_CYCLES - 1));
    assign min_end = sec_end && (secs == 6'h3B);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc <= 26'h0000000;
            secs <= 6'h00;
            mins <= 6'h00;
            tick <= '0;
        end
        else if (restart)
        begin
            cyc <= 26'h0000000;
            secs <= 6'h00;
            mins <= 6'h00;
            tick <= '0;
        end
        else
        begin
            cyc <= sec_end ? 26'h0000000 : cyc + 26'h0000001;
            if (sec_end)
                secs <= (secs == 6'h3B) ? 6'h00 : secs + 6'h01;
            if (min_end)
                mins <= (mins == 6'h3B) ? 6'h00 : mins + 6'h01;
            tick.sec <= sec_end;
            tick.min <= min_end;
            tick.hour <= min_end && (mins == 6'h3B);
        end
    end

endmodule : balance_timebase

// [design/cell_balance_control.sv]
// Purpose: Balance control register and mode sequencer behind APB
// Assumes: Timeout and calibration exits and scan strobes come from logic on pclk
// Notes:   Zero-wait APB slave, unmapped addresses answer pslverr
//
// How it works
// - Starting write clears timer and launches mode
// - State 00 disabled, 01 active
// - Normal end sets state 10
// - Unexpected stop sets state 11
// - Modes 000-011: off, discharge, manual
// - Modes 1xx: automatic individual or group
// - Init request restarts filter on first scan when measurement field is 1x
// - Sixteen scans without threshold checks after init
// - Hold 01 keeps shutdown high during discharge or automatic operation
// - Hold 10 adds max of 5min, expiry/16, after discharge or automatic modes
// - Hold 11 keeps shutdown high until removed, once set by discharge or automatic operation
// - Duty field sets active slots per period
// - Done enable gates completion into summary
// - Thermal enable lets temperature alert halt
// - Measurement field enables measurements and checks
// - Cells below threshold suspended in automatic
// - Measurement requested after each even/odd pair in discharge or automatic modes
// - Status clears only on disable or start
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "cell_balance_map.svh"
module cell_balance_control
    import cell_balance_pkg::*;
#(
    parameter int SEC_CYCLES = `SEC_CYCLES,
    parameter int SLOT_CYCLES = 256,
    parameter int NOL_CYCLES = 8
)
(
    input wire logic pclk,                   // Clock, 40 MHz
    input wire logic presetn,                // Async reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB enable
    input wire logic pwrite,                 // APB direction
    input wire logic [11:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,          // APB write data
    output logic [31:0] prdata,              // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error
    input wire logic temperature_alert,      // Pin, asynchronous
    input wire logic timeout_alert,          // Pulse, timeout exit
    input wire logic cal_fault_alert,        // Pulse, calibration fault
    input wire logic scan_done,              // Pulse, measurement scan ended
    input wire logic [9:0] balance_expiry,   // Governing expiry
    input wire logic [9:0] max_expiry,       // Largest expiry interval
    input wire logic [13:0] cell_below_uv,   // Per cell under threshold
    output logic [13:0] cell_switch_en,      // Balance switch drive
    output logic shutdown_line,              // Shutdown hold drive
    output logic filter_init,                // Filter restart request
    output logic uv_check_en,                // Threshold checking live
    output logic meas_request,               // Pulse, supervisory measurement
    output logic completion_alert,           // Sticky normal completion
    output logic balance_alert_summary       // Summary alert
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] unit_of(input logic [2:0] m);
        case (m)
            `MODE_DISABLED: unit_of = `UNIT_NONE;
            `MODE_DISCHARGE: unit_of = `UNIT_HOUR;
            `MODE_MAN_SEC, `MODE_AUTO_IND_SEC, `MODE_AUTO_GRP_SEC: unit_of = `UNIT_SEC;
            default: unit_of = `UNIT_MIN;
        endcase
    endfunction : unit_of

    function automatic logic is_automated(input logic [2:0] m);
        is_automated = m[2] || (m == `MODE_DISCHARGE);
    endfunction : is_automated

    // Extension in seconds; hours scale by 3600/16 = 225
    function automatic logic [17:0] hold_ext_s(input logic [1:0] u, input logic [9:0] e);
        logic [17:0] s;
        case (u)
            `UNIT_SEC: s = 18'(e) >> 4;
            `UNIT_MIN: s = (18'(e) * 18'h0003C) >> 4;
            default: s = 18'(e) * 18'h000E1;
        endcase
        hold_ext_s = (s > 18'(`HOLD_MIN_S)) ? s : 18'(`HOLD_MIN_S);
    endfunction : hold_ext_s

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ctrl_t ctrl;
    tick_t tick;
    run_state_t run;
    logic [1:0] balance_state;
    logic [9:0] balance_elapsed_timer;
    logic [17:0] hold_left;
    logic [4:0] settle;
    logic [2:0] temp_sync;
    logic temp_level;
    logic keep_latch;
    logic [15:0] slot_cnt;
    logic [3:0] slot_idx;
    logic phase;
    logic access;
    logic wr_ctrl;
    logic start;
    logic stop_wr;
    logic unit_tick;
    logic abnormal;
    logic normal;
    logic duty_on;
    logic pair_end;
    logic [1:0] unit;

    assign access = psel && penable && pready;
    assign wr_ctrl = access && pwrite && (paddr == `BAL_CTRL_ADDR);
    assign start = wr_ctrl && (pwdata[13:11] != `MODE_DISABLED);
    assign stop_wr = wr_ctrl && (pwdata[13:11] == `MODE_DISABLED);
    assign unit = unit_of(ctrl.balance_mode_sel);
    assign unit_tick = (unit == `UNIT_SEC) ? tick.sec : (unit == `UNIT_MIN) ? tick.min : tick.hour;
    assign abnormal = (temp_level && ctrl.thermal_exit_en) || timeout_alert || cal_fault_alert;
    assign normal = ((balance_expiry != `EXPIRY_INFINITE) && (balance_elapsed_timer >= balance_expiry))
        || (ctrl.balance_mode_sel[2] && uv_check_en && (&cell_below_uv));
    assign duty_on = (slot_idx <= ctrl.balance_duty)
        && !(slot_idx == 4'h0 && slot_cnt < 16'(NOL_CYCLES));
    assign pair_end = phase && (slot_idx == 4'hF) && (slot_cnt == 16'(SLOT_CYCLES - 1));

    balance_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .restart(start),
        .tick(tick)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr != `BAL_CTRL_ADDR) && (paddr != `BAL_STATUS_ADDR);
            if (psel && !penable && !pwrite && paddr == `BAL_CTRL_ADDR)
                prdata <= {16'h0000, balance_state, ctrl};
            else if (psel && !penable && !pwrite && paddr == `BAL_STATUS_ADDR)
                prdata <= {16'h0000, balance_state, unit, 2'h0, balance_elapsed_timer};
            else
                prdata <= 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `BAL_CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= pwdata[13:0];
    end

    // ----------------------------------------
    // Temperature alert pin
    // ----------------------------------------
    // Level moves only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            temp_sync <= 3'h0;
            temp_level <= 1'b0;
        end
        else
        begin
            temp_sync <= {temp_sync[1:0], temperature_alert};
            if (temp_sync[1] == temp_sync[2])
                temp_level <= temp_sync[2];
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= RUN_IDLE;
            balance_state <= `STATE_OFF;
            hold_left <= 18'h00000;
        end
        else if (start)
        begin
            run <= RUN_ACTIVE;
            balance_state <= `STATE_ACTIVE;
        end
        else if (stop_wr)
        begin
            run <= RUN_IDLE;
            balance_state <= `STATE_OFF;
        end
        else
        begin
            case (run)
                RUN_ACTIVE:
                begin
                    if (abnormal || normal)
                    begin
                        balance_state <= abnormal ? `STATE_HALT : `STATE_DONE;
                        hold_left <= hold_ext_s(unit, max_expiry);
                        run <= (ctrl.shutdown_hold_sel == `HOLD_EXT && is_automated(ctrl.balance_mode_sel))
                            ? RUN_HOLD : RUN_IDLE;
                    end
                end
                RUN_HOLD:
                begin
                    if (hold_left == 18'h00000)
                        run <= RUN_IDLE;
                    else if (tick.sec)
                        hold_left <= hold_left - 18'h00001;
                end
                default:
                    run <= RUN_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            balance_elapsed_timer <= 10'h000;
        else if (start)
            balance_elapsed_timer <= 10'h000;
        else if (run == RUN_ACTIVE && unit_tick)
            balance_elapsed_timer <= balance_elapsed_timer + 10'h001;
    end

    // ----------------------------------------
    // Duty slots and measurement requests
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_cnt <= 16'h0000;
            slot_idx <= 4'h0;
            phase <= 1'b0;
            meas_request <= 1'b0;
        end
        else if (run != RUN_ACTIVE || start)
        begin
            slot_cnt <= 16'h0000;
            slot_idx <= 4'h0;
            phase <= 1'b0;
            meas_request <= 1'b0;
        end
        else
        begin
            if (slot_cnt == 16'(SLOT_CYCLES - 1))
            begin
                slot_cnt <= 16'h0000;
                slot_idx <= slot_idx + 4'h1;
                if (slot_idx == 4'hF)
                    phase <= !phase;
            end
            else
                slot_cnt <= slot_cnt + 16'h0001;
            meas_request <= pair_end && is_automated(ctrl.balance_mode_sel)
                && ctrl.embedded_meas_en[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cell_switch_en <= 14'h0000;
        else
        begin
            for (int i = 0; i < 14; i++)
                cell_switch_en[i] <= (run == RUN_ACTIVE) && !start && duty_on && (phase == i[0])
                    && !(ctrl.balance_mode_sel[2] && uv_check_en && cell_below_uv[i]);
        end
    end

    // ----------------------------------------
    // Filter settling and threshold checks
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filter_init <= 1'b0;
            settle <= 5'h00;
            uv_check_en <= 1'b0;
        end
        else if (start)
        begin
            filter_init <= pwdata[10] && pwdata[1];
            settle <= pwdata[10] ? `SETTLE_SCANS : 5'h00;
            uv_check_en <= 1'b0;
        end
        else
        begin
            if (scan_done)
            begin
                filter_init <= 1'b0;
                if (settle != 5'h00)
                    settle <= settle - 5'h01;
            end
            uv_check_en <= (run == RUN_ACTIVE) && !stop_wr && (ctrl.embedded_meas_en == `MEAS_CHECK)
                && (settle == 5'h00);
        end
    end

    // ----------------------------------------
    // Shutdown hold and alerts
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            keep_latch <= 1'b0;
            shutdown_line <= 1'b0;
        end
        else
        begin
            if (ctrl.shutdown_hold_sel != `HOLD_KEEP)
                keep_latch <= 1'b0;
            else if (run == RUN_ACTIVE && is_automated(ctrl.balance_mode_sel))
                keep_latch <= 1'b1;
            shutdown_line <= (run == RUN_ACTIVE && is_automated(ctrl.balance_mode_sel)
                && ctrl.shutdown_hold_sel != `HOLD_NONE)
                || run == RUN_HOLD || (keep_latch && ctrl.shutdown_hold_sel == `HOLD_KEEP);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            completion_alert <= 1'b0;
            balance_alert_summary <= 1'b0;
        end
        else
        begin
            if (run == RUN_ACTIVE && !abnormal && normal && !wr_ctrl)
                completion_alert <= 1'b1;
            else if (wr_ctrl)
                completion_alert <= 1'b0;
            balance_alert_summary <= (completion_alert && ctrl.done_alert_en)
                || (balance_state == `STATE_HALT);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_clears_a: assert property (start |=> balance_elapsed_timer == 10'h000
        && balance_state == `STATE_ACTIVE) else $error("start did not clear timer");
    disable_off_a: assert property (stop_wr |=> balance_state == `STATE_OFF && !completion_alert)
        else $error("disable did not clear state");
    normal_done_a: assert property (run == RUN_ACTIVE && normal && !abnormal && !wr_ctrl
        |=> balance_state == `STATE_DONE && completion_alert) else $error("normal end missed");
    halt_state_a: assert property (run == RUN_ACTIVE && abnormal && !wr_ctrl
        |=> balance_state == `STATE_HALT) else $error("abnormal end missed");
    timer_frozen_a: assert property (run != RUN_ACTIVE && !start
        |=> $stable(balance_elapsed_timer)) else $error("timer moved while inactive");
    settle_gate_a: assert property (uv_check_en |-> $past(settle) == 5'h00
        && ctrl.embedded_meas_en == `MEAS_CHECK) else $error("checks during settling");
    hold_op_a: assert property (run == RUN_ACTIVE && is_automated(ctrl.balance_mode_sel)
        && ctrl.shutdown_hold_sel == `HOLD_OP |=> shutdown_line) else $error("shutdown not held");
    hold_keep_a: assert property (keep_latch && ctrl.shutdown_hold_sel == `HOLD_KEEP
        |=> shutdown_line) else $error("shutdown keep lost");
    duty_slot_a: assert property (cell_switch_en != 14'h0000
        |-> $past(slot_idx) <= $past(ctrl.balance_duty)) else $error("switch on outside duty");
    summary_gate_a: assert property (completion_alert && ctrl.done_alert_en
        |=> balance_alert_summary) else $error("summary missed completion");
    meas_pair_a: assert property (meas_request |-> $past(pair_end)
        && $past(ctrl.embedded_meas_en[1])) else $error("measurement off pair end");

    start_seen_c: cover property (start ##[1:20] run == RUN_ACTIVE);
    normal_end_c: cover property (run == RUN_ACTIVE ##1 balance_state == `STATE_DONE);
    halt_end_c: cover property (run == RUN_ACTIVE ##1 balance_state == `STATE_HALT);
    hold_ext_c: cover property (run == RUN_HOLD);

endmodule : cell_balance_control

// [testbench/cell_balance_control_tb.sv]
// Purpose: Self-checking bench for the balance control register and sequencer
// Assumes: Short time parameters, zero-wait APB slave, exits driven by the bench
// Notes:   Control fields drawn from a fixed-seed xorshift
`timescale 1ns/1ps
`include "cell_balance_map.svh"
module cell_balance_control_tb
    import cell_balance_pkg::*;
;
    localparam int SECC = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic temperature_alert = 1'b0;
    logic timeout_alert = 1'b0;
    logic cal_fault_alert = 1'b0;
    logic scan_done = 1'b0;
    logic [9:0] balance_expiry = `EXPIRY_INFINITE;
    logic [9:0] max_expiry = 10'h000;
    logic [13:0] cell_below_uv = 14'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [13:0] cell_switch_en;
    logic shutdown_line;
    logic filter_init;
    logic uv_check_en;
    logic meas_request;
    logic completion_alert;
    logic balance_alert_summary;
    logic [31:0] seed = 32'h955200A7;
    logic [31:0] rdv;
    logic [31:0] r;
    logic [31:0] n_on;
    logic [31:0] n_uv;
    logic [31:0] n_req;
    logic err;
    ctrl_t c;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    cell_balance_control #(.SEC_CYCLES(SECC), .SLOT_CYCLES(4), .NOL_CYCLES(1)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temperature_alert(temperature_alert), .timeout_alert(timeout_alert),
        .cal_fault_alert(cal_fault_alert), .scan_done(scan_done), .balance_expiry(balance_expiry),
        .max_expiry(max_expiry), .cell_below_uv(cell_below_uv), .cell_switch_en(cell_switch_en),
        .shutdown_line(shutdown_line), .filter_init(filter_init), .uv_check_en(uv_check_en),
        .meas_request(meas_request), .completion_alert(completion_alert),
        .balance_alert_summary(balance_alert_summary));

    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [1:0] unit_of(input int m);
        return (m == 1) ? `UNIT_HOUR : (m % 2 == 1) ? `UNIT_MIN : `UNIT_SEC;
    endfunction : unit_of

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic scan(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            scan_done <= 1'b1;
            @(posedge pclk);
            scan_done <= 1'b0;
            cyc(2);
        end
    endtask : scan

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        cyc(10);
        presetn <= 1'b1;
        apb(0, `BAL_CTRL_ADDR, 0);
        check("ctrl reset", rdv, 0);
        apb(0, `BAL_STATUS_ADDR, 0);
        check("status reset", rdv, 0);
        apb(0, 12'h0F0, 0);
        check("unmapped error", err, 1);
        $display("test reset done");
        // Upper write bits are junk; state field must ignore them
        for (int m = 1; m < 8; m++)
        begin
            r = rnd();
            c = r[13:0];
            c.balance_mode_sel = m[2:0];
            apb(1, `BAL_CTRL_ADDR, {r[31:14], c});
            apb(0, `BAL_CTRL_ADDR, 0);
            check("mode start", rdv, {16'h0, `STATE_ACTIVE, c});
            apb(0, `BAL_STATUS_ADDR, 0);
            check("unit timer", rdv, {16'h0, `STATE_ACTIVE, unit_of(m), 12'h000});
        end
        $display("test modes done");
        balance_expiry <= 10'h002;
        for (int k = 0; k < 2; k++)
        begin
            c = '0;
            c.balance_mode_sel = `MODE_MAN_SEC;
            c.done_alert_en = k[0];
            apb(1, `BAL_CTRL_ADDR, 32'(c));
            cyc(4 * SECC);
            apb(0, `BAL_STATUS_ADDR, 0);
            check("normal end", rdv, 32'h9002);
            cyc(2 * SECC);
            apb(0, `BAL_STATUS_ADDR, 0);
            check("timer stopped", rdv, 32'h9002);
            check("completion", completion_alert, 1);
            check("summary", balance_alert_summary, k);
        end
        apb(1, `BAL_CTRL_ADDR, 0);
        apb(0, `BAL_CTRL_ADDR, 0);
        check("disabled", rdv, 0);
        check("completion cleared", completion_alert, 0);
        $display("test normal end done");
        // Exits: timeout, calibration, thermal on, thermal off
        balance_expiry <= `EXPIRY_INFINITE;
        for (int k = 0; k < 4; k++)
        begin
            c = '0;
            c.balance_mode_sel = `MODE_AUTO_IND_SEC;
            c.thermal_exit_en = (k != 3);
            c.shutdown_hold_sel = (k == 0) ? `HOLD_OP : (k == 1) ? `HOLD_KEEP : `HOLD_NONE;
            apb(1, `BAL_CTRL_ADDR, 32'(c));
            cyc(3);
            check("hold active", shutdown_line, k < 2);
            timeout_alert <= (k == 0);
            cal_fault_alert <= (k == 1);
            temperature_alert <= (k > 1);
            @(posedge pclk);
            timeout_alert <= 1'b0;
            cal_fault_alert <= 1'b0;
            cyc(10);
            temperature_alert <= 1'b0;
            cyc(4);
            apb(0, `BAL_CTRL_ADDR, 0);
            check("halt state", rdv[15:14], (k == 3) ? 1 : 3);
            check("hold after", shutdown_line, k == 1);
        end
        apb(1, `BAL_CTRL_ADDR, 0);
        cyc(3);
        check("hold removed", shutdown_line, 0);
        $display("test exits done");
        c = '0;
        c.balance_mode_sel = `MODE_AUTO_IND_SEC;
        c.shutdown_hold_sel = `HOLD_EXT;
        balance_expiry <= 10'h001;
        apb(1, `BAL_CTRL_ADDR, 32'(c));
        cyc(3 * SECC);
        apb(0, `BAL_CTRL_ADDR, 0);
        check("ext op done", rdv[15:14], 2);
        cyc(290 * SECC);
        check("ext held", shutdown_line, 1);
        cyc(20 * SECC);
        check("ext over", shutdown_line, 0);
        $display("test hold extension done");
        balance_expiry <= `EXPIRY_INFINITE;
        c = '0;
        c.balance_mode_sel = `MODE_AUTO_GRP_SEC;
        c.filter_init_req = 1'b1;
        c.embedded_meas_en = `MEAS_CHECK;
        apb(1, `BAL_CTRL_ADDR, 32'(c));
        cyc(3);
        check("filter init", filter_init, 1);
        scan(1);
        check("filter init end", filter_init, 0);
        scan(14);
        check("uv settling", uv_check_en, 0);
        scan(4);
        check("uv settled", uv_check_en, 1);
        $display("test filter done");
        // Duty corners and one random; cell 0 sits below threshold
        cell_below_uv <= 14'h0001;
        for (int k = 0; k < 3; k++)
        begin
            r = rnd();
            c = '0;
            c.balance_mode_sel = `MODE_AUTO_IND_SEC;
            c.embedded_meas_en = (k == 2) ? 2'b10 : `MEAS_CHECK;
            c.balance_duty = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : r[3:0];
            apb(1, `BAL_CTRL_ADDR, 32'(c));
            cyc(4);
            check("uv gate", uv_check_en, k != 2);
            n_on = 0;
            n_uv = 0;
            n_req = 0;
            repeat (256)
            begin
                @(posedge pclk);
                n_on = n_on + cell_switch_en[2];
                n_uv = n_uv + cell_switch_en[0];
                n_req = n_req + meas_request;
            end
            check("duty", n_on, 2 * (4 * (c.balance_duty + 1) - 1));
            check("uv suspend", n_uv, (k == 2) ? n_on : 0);
            check("meas request", n_req, 2);
        end
        $display("test duty done");
        end_of_test();
    end
endmodule : cell_balance_control_tb
